// ==== rtl/flash_resume_powerdown_id.sv ====
/*
  Host controller that drives a serial flash through its pins for
  resume, suspend, power-down, release and identification reads.
  Assumes an AHB-Lite master on hclk and a flash in SPI mode 0.
*/
`timescale 1ns/1ps
module flash_resume_powerdown_id #(
  parameter int HALF_DIV = flc_pkg::SCLK_HALF
) (
  input  wire logic        hclk,      // System clock
  input  wire logic        hresetn,   // Async reset, low active
  input  wire logic        ce,        // Clock enable
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write strobe
  input  wire logic [2:0]  hsize,     // Transfer size
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Slave ready
  output logic [31:0]      hrdata,    // Read data
  output logic             hresp,     // Response
  output logic             cs_n,      // Flash chip select
  output logic             sclk,      // Flash serial clock
  output logic [3:0]       io_out,    // Data lines out
  output logic [3:0]       io_oe_n,   // Data line drive, low drives
  input  wire logic [3:0]  io_in      // Data lines in
);
  typedef struct packed {
    flc_pkg::st_type st;
    logic [3:0]  cmd;
    logic [3:0]  lcmd;
    logic        pend;
    logic [1:0]  dcs;
    logic        pd;
    logic [7:0]  half;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  io_out;
    logic [3:0]  io_oe_n;
    logic [7:0]  sh;
    logic [6:0]  cnt;
    logic [6:0]  fclk;
    logic [63:0] rx;
    logic [11:0] gap;
    logic [11:0] guard;
    logic [11:0] hi_cnt;
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic        a_wr;
    logic [7:0]  a_ofs;
    logic [31:0] hrdata;
    logic        hready_o;
  } state_type;

  localparam state_type RST = '{st: flc_pkg::ST_IDLE, cs_n: 1'b1,
                                io_oe_n: 4'hf, hready_o: 1'b1, default: '0};

  if (HALF_DIV < 3 || HALF_DIV > 255) begin : g_bad_div
    $error("HALF_DIV must lie in 3..255");
  end

  state_type r;
  state_type n;

  function automatic logic [7:0] opcode(logic [3:0] c);
    case (c)
      flc_pkg::CMD_RESUME:  opcode = flc_pkg::OP_RESUME;
      flc_pkg::CMD_SUSPEND: opcode = flc_pkg::OP_SUSPEND;
      flc_pkg::CMD_PDOWN:   opcode = flc_pkg::OP_PDOWN;
      flc_pkg::CMD_ID_SGL:  opcode = flc_pkg::OP_ID_SGL;
      flc_pkg::CMD_ID_DUAL: opcode = flc_pkg::OP_ID_DUAL;
      flc_pkg::CMD_ID_QUAD: opcode = flc_pkg::OP_ID_QUAD;
      flc_pkg::CMD_UID:     opcode = flc_pkg::OP_UID;
      default:              opcode = flc_pkg::OP_RELEASE;
    endcase
  endfunction : opcode

  // Lanes per clock in a phase
  function automatic logic [2:0] width(flc_pkg::st_type p, logic [3:0] c);
    width = 3'd1;
    if (p == flc_pkg::ST_ADDR || p == flc_pkg::ST_MODE || p == flc_pkg::ST_READ)
    begin
      if (c == flc_pkg::CMD_ID_DUAL)
        width = 3'd2;
      else if (c == flc_pkg::CMD_ID_QUAD)
        width = 3'd4;
    end
  endfunction : width

  // Clocks in a phase; zero skips it
  function automatic logic [6:0] ph_len(flc_pkg::st_type p, logic [3:0] c, logic d8);
    ph_len = 7'd0;
    case (p)
      flc_pkg::ST_OPC:
        ph_len = 7'd8;
      flc_pkg::ST_PRE:
        if (c == flc_pkg::CMD_ID_QUAD)
          ph_len = 7'd4;
        else if (c == flc_pkg::CMD_REL_ID)
          ph_len = 7'd24;
        else if (c == flc_pkg::CMD_UID)
          ph_len = 7'd32;
      flc_pkg::ST_ADDR:
        if (c == flc_pkg::CMD_ID_SGL)
          ph_len = 7'd24;
        else if (c == flc_pkg::CMD_ID_DUAL)
          ph_len = 7'd12;
        else if (c == flc_pkg::CMD_ID_QUAD)
          ph_len = 7'd6;
      flc_pkg::ST_MODE:
        if (c == flc_pkg::CMD_ID_DUAL)
          ph_len = 7'd4;
        else if (c == flc_pkg::CMD_ID_QUAD)
          ph_len = 7'd2;
      flc_pkg::ST_DUM:
        if (c == flc_pkg::CMD_ID_DUAL)
          ph_len = d8 ? 7'd4 : 7'd0;
        else if (c == flc_pkg::CMD_ID_QUAD)
          ph_len = d8 ? 7'd6 : 7'd4;
      flc_pkg::ST_READ:
        if (c == flc_pkg::CMD_REL_ID)
          ph_len = 7'd8;
        else if (c == flc_pkg::CMD_ID_SGL)
          ph_len = 7'd16;
        else if (c == flc_pkg::CMD_ID_DUAL)
          ph_len = 7'd8;
        else if (c == flc_pkg::CMD_ID_QUAD)
          ph_len = 7'd4;
        else if (c == flc_pkg::CMD_UID)
          ph_len = 7'd64;
      default:
        ph_len = 7'd0;
    endcase
  endfunction : ph_len

  function automatic flc_pkg::st_type step(flc_pkg::st_type p);
    case (p)
      flc_pkg::ST_OPC:  step = flc_pkg::ST_PRE;
      flc_pkg::ST_PRE:  step = flc_pkg::ST_ADDR;
      flc_pkg::ST_ADDR: step = flc_pkg::ST_MODE;
      flc_pkg::ST_MODE: step = flc_pkg::ST_DUM;
      flc_pkg::ST_DUM:  step = flc_pkg::ST_READ;
      default:          step = flc_pkg::ST_END;
    endcase
  endfunction : step

  // Next phase that has clocks, or the frame end
  function automatic flc_pkg::st_type after(flc_pkg::st_type p, logic [3:0] c, logic d8);
    flc_pkg::st_type q;
    q = step(p);
    for (int i = 0; i < 5; i++)
    begin
      if (q != flc_pkg::ST_END && ph_len(q, c, d8) == 7'd0)
        q = step(q);
    end
    after = q;
  endfunction : after

  // Returns {drive enables low-active, data}
  function automatic logic [7:0] drive(flc_pkg::st_type p, logic [3:0] c, logic [7:0] s);
    drive = {4'b1111, 4'h0};
    if (p == flc_pkg::ST_OPC || p == flc_pkg::ST_ADDR || p == flc_pkg::ST_MODE)
    begin
      case (width(p, c))
        3'd2:    drive = {4'b1100, 2'b00, s[7:6]};
        3'd4:    drive = {4'b0000, s[7:4]};
        default: drive = {4'b1110, 3'b000, s[7]};
      endcase
    end
  endfunction : drive

  function automatic logic [11:0] gap_len(logic [3:0] c);
    case (c)
      flc_pkg::CMD_PDOWN:   gap_len = flc_pkg::DP_CYC;
      flc_pkg::CMD_RELEASE: gap_len = flc_pkg::RES1_CYC;
      flc_pkg::CMD_REL_ID:  gap_len = flc_pkg::RES2_CYC;
      default:              gap_len = flc_pkg::CSH_CYC;
    endcase
  endfunction : gap_len

  always_comb
  begin
    flc_pkg::st_type p;
    logic [2:0]      w;
    logic            ahb;
    n   = r;
    p   = flc_pkg::ST_END;
    w   = width(r.st, r.cmd);
    ahb = hsel & hready & htrans[1];
    n.sy1 = io_in;
    n.sy2 = r.sy1;
    if (r.guard != 12'h000)
      n.guard = r.guard - 12'h001;
    if (!r.cs_n)
      n.hi_cnt = 12'h000;
    else if (r.hi_cnt != 12'hfff)
      n.hi_cnt = r.hi_cnt + 12'h001;
    // Address phase; reads answer with zero wait
    n.a_wr   = ahb & hwrite;
    n.a_ofs  = haddr[7:0];
    n.hrdata = 32'h0000_0000;
    if (ahb && !hwrite)
    begin
      case (haddr[7:0])
        flc_pkg::OFS_CMD:  n.hrdata = {28'h0000000, r.cmd};
        flc_pkg::OFS_CFG:  n.hrdata = {30'h0, r.dcs};
        flc_pkg::OFS_STAT:
        begin
          n.hrdata[flc_pkg::STAT_BUSY]  = r.pend | (r.st != flc_pkg::ST_IDLE);
          n.hrdata[flc_pkg::STAT_GUARD] = r.guard != 12'h000;
          n.hrdata[flc_pkg::STAT_PD]    = r.pd;
        end
        flc_pkg::OFS_DLO:  n.hrdata = r.rx[31:0];
        flc_pkg::OFS_DHI:  n.hrdata = r.rx[63:32];
        default:           n.hrdata = 32'h0000_0000;
      endcase
    end
    // Data phase writes; a command while busy is dropped
    if (r.a_wr)
    begin
      if (r.a_ofs == flc_pkg::OFS_CMD && r.st == flc_pkg::ST_IDLE && !r.pend &&
          hwdata[31:4] == 28'h0000000 && hwdata[3:0] <= flc_pkg::CMD_UID)
      begin
        n.cmd  = hwdata[3:0];
        n.pend = 1'b1;
      end
      if (r.a_ofs == flc_pkg::OFS_CFG)
        n.dcs = hwdata[1:0];
    end
    case (r.st)
      flc_pkg::ST_IDLE:
        if (r.pend && !(r.cmd == flc_pkg::CMD_SUSPEND && r.guard != 12'h000))
        begin
          n.pend = 1'b0;
          n.cs_n = 1'b0;
          n.st   = flc_pkg::ST_OPC;
          n.cnt  = 7'd8;
          n.sh   = opcode(r.cmd);
          n.half = 8'(HALF_DIV - 1);
          n.rx   = 64'h0;
          n.fclk = 7'd0;
          {n.io_oe_n, n.io_out} = drive(flc_pkg::ST_OPC, r.cmd, opcode(r.cmd));
        end
      flc_pkg::ST_OPC, flc_pkg::ST_PRE, flc_pkg::ST_ADDR, flc_pkg::ST_MODE,
      flc_pkg::ST_DUM, flc_pkg::ST_READ:
        if (r.half != 8'h00)
          n.half = r.half - 8'h01;
        else
        begin
          n.half = 8'(HALF_DIV - 1);
          if (!r.sclk)
            n.sclk = 1'b1;
          else
          begin
            // Falling edge: take read bits, move to next bit
            n.sclk = 1'b0;
            n.fclk = r.fclk + 7'd1;
            if (r.st == flc_pkg::ST_READ)
            begin
              case (w)
                3'd2:    n.rx = {r.rx[61:0], r.sy2[1:0]};
                3'd4:    n.rx = {r.rx[59:0], r.sy2};
                default: n.rx = {r.rx[62:0], r.sy2[1]};
              endcase
            end
            n.sh = r.sh << w;
            if (r.cnt == 7'd1)
            begin
              p     = after(r.st, r.cmd, r.dcs[0]);
              n.st  = p;
              n.cnt = ph_len(p, r.cmd, r.dcs[0]);
              n.sh  = (p == flc_pkg::ST_MODE) ? flc_pkg::MODE_BYTE : 8'h00;
            end
            else
              n.cnt = r.cnt - 7'd1;
            {n.io_oe_n, n.io_out} = drive(n.st, r.cmd, n.sh);
          end
        end
      flc_pkg::ST_END:
        if (r.half != 8'h00)
          n.half = r.half - 8'h01;
        else
        begin
          n.cs_n = 1'b1;
          n.st   = flc_pkg::ST_GAP;
          n.gap  = gap_len(r.cmd);
          n.lcmd = r.cmd;
          if (r.cmd == flc_pkg::CMD_RESUME)
            n.guard = flc_pkg::ERS_CYC;
          if (r.cmd == flc_pkg::CMD_PDOWN)
            n.pd = 1'b1;
          else if (r.cmd == flc_pkg::CMD_RELEASE || r.cmd == flc_pkg::CMD_REL_ID)
            n.pd = 1'b0;
        end
      flc_pkg::ST_GAP:
        if (r.gap != 12'h000)
          n.gap = r.gap - 12'h001;
        else
          n.st = flc_pkg::ST_IDLE;
      default:
        n.st = flc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= RST;
    else if (ce)
      r <= n;
  end

  assign hreadyout = r.hready_o;
  assign hrdata    = r.hrdata;
  assign hresp     = 1'b0 & r.hready_o;
  assign cs_n      = r.cs_n;
  assign sclk      = r.sclk;
  assign io_out    = r.io_out;
  assign io_oe_n   = r.io_oe_n;

  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_read_begin;
    $rose(r.st == flc_pkg::ST_READ);
  endsequence
  sequence s_frame_end;
    $rose(r.cs_n);
  endsequence
  sequence s_frame_start;
    $fell(r.cs_n);
  endsequence

  AST_CS_AFTER8: assert property (
    s_frame_end ##0 (r.cmd <= flc_pkg::CMD_RELEASE) |-> r.fclk == 7'd8)
    else $error("chip select not raised after eight clocks");
  AST_SUS_GUARD: assert property (
    s_frame_start ##0 (r.cmd == flc_pkg::CMD_SUSPEND) |-> $past(r.guard) == 12'h000)
    else $error("suspend sent too soon after resume");
  AST_REL_GAP: assert property (
    s_frame_start ##0 (r.lcmd == flc_pkg::CMD_RELEASE) |-> $past(r.hi_cnt) >= flc_pkg::RES1_CYC)
    else $error("release wait too short");
  AST_RES2_GAP: assert property (
    s_frame_start ##0 (r.lcmd == flc_pkg::CMD_REL_ID) |-> $past(r.hi_cnt) >= flc_pkg::RES2_CYC)
    else $error("release with ID wait too short");
  AST_ADDR_ZERO: assert property (
    r.st == flc_pkg::ST_ADDR |-> r.io_out == 4'h0)
    else $error("address not zero");
  AST_ID_SGL: assert property (
    s_read_begin ##0 (r.cmd == flc_pkg::CMD_ID_SGL) |-> r.fclk == 7'd32)
    else $error("single ID read header length wrong");
  AST_DUAL_ADDR: assert property (
    $rose(r.st == flc_pkg::ST_MODE) ##0 (r.cmd == flc_pkg::CMD_ID_DUAL) |-> r.fclk == 7'd20)
    else $error("dual address length wrong");
  AST_MODE_F: assert property (
    $rose(r.st == flc_pkg::ST_MODE) |-> (r.io_out & ~r.io_oe_n) == ~r.io_oe_n)
    else $error("mode byte not Fx");
  AST_DUAL_DUMMY: assert property (
    s_read_begin ##0 (r.cmd == flc_pkg::CMD_ID_DUAL) |-> r.fclk == (r.dcs[0] ? 7'd28 : 7'd24))
    else $error("dual dummy count wrong");
  AST_QUAD_ADDR: assert property (
    $rose(r.st == flc_pkg::ST_ADDR) ##0 (r.cmd == flc_pkg::CMD_ID_QUAD) |-> r.fclk == 7'd12)
    else $error("quad pre-address dummy wrong");
  AST_QUAD_DUMMY: assert property (
    s_read_begin ##0 (r.cmd == flc_pkg::CMD_ID_QUAD) |-> r.fclk == (r.dcs[0] ? 7'd26 : 7'd24))
    else $error("quad dummy count wrong");
  AST_UID_DUMMY: assert property (
    s_read_begin ##0 (r.cmd == flc_pkg::CMD_UID) |-> r.fclk == 7'd40 ##1 r.st == flc_pkg::ST_READ)
    else $error("unique ID dummy length wrong");
endmodule : flash_resume_powerdown_id

// ==== shared/flc_pkg.sv ====
/*
  Constants, command codes and the state type of the serial flash
  identification and power controller.
  Assumes a 100 MHz hclk and a flash that samples on rising sclk.
*/
package flc_pkg;
  localparam logic [7:0] OFS_CMD  = 8'h00;
  localparam logic [7:0] OFS_CFG  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DLO  = 8'h0c;
  localparam logic [7:0] OFS_DHI  = 8'h10;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_GUARD = 1;
  localparam int STAT_PD    = 2;

  localparam logic [3:0] CMD_RESUME   = 4'h0;
  localparam logic [3:0] CMD_SUSPEND  = 4'h1;
  localparam logic [3:0] CMD_PDOWN    = 4'h2;
  localparam logic [3:0] CMD_RELEASE  = 4'h3;
  localparam logic [3:0] CMD_REL_ID   = 4'h4;
  localparam logic [3:0] CMD_ID_SGL   = 4'h5;
  localparam logic [3:0] CMD_ID_DUAL  = 4'h6;
  localparam logic [3:0] CMD_ID_QUAD  = 4'h7;
  localparam logic [3:0] CMD_UID      = 4'h8;

  localparam logic [7:0] OP_RESUME  = 8'h7a;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_PDOWN   = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  localparam logic [7:0] OP_ID_SGL  = 8'h90;
  localparam logic [7:0] OP_ID_DUAL = 8'h92;
  localparam logic [7:0] OP_ID_QUAD = 8'h94;
  localparam logic [7:0] OP_UID     = 8'h4b;
  localparam logic [7:0] MODE_BYTE  = 8'hf0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RES1_NS     = 3000;
  localparam int T_RES2_NS     = 1800;
  localparam int T_DP_NS       = 3000;
  localparam int T_ERS_NS      = 20000;
  localparam int T_CSH_NS      = 50;
  localparam logic [11:0] RES1_CYC = 12'((T_RES1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] RES2_CYC = 12'((T_RES2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] DP_CYC   = 12'((T_DP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ERS_CYC  = 12'((T_ERS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CSH_CYC  = 12'((T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SCLK_HALF = 4;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_PRE, ST_ADDR, ST_MODE, ST_DUM, ST_READ, ST_END, ST_GAP
  } st_type;
endpackage : flc_pkg

// ==== test/flash_model.sv ====
/*
  Behavioural serial flash facing the controller bench.
  Assumes mode 0 pins and framing as the package command codes give.
*/
`timescale 1ns/1ps
module flash_model #(
  parameter logic [7:0]  MFR = 8'h5a,                // Arbitrary value
  parameter logic [7:0]  DEV = 8'h17,                // Arbitrary value
  parameter logic [63:0] UID = 64'h0123456789abcdef, // Arbitrary value
  parameter int          ERASE_CYC = 8000
) (
  input  wire logic       hclk,     // Timer clock
  input  wire logic       cs_n,     // Chip select
  input  wire logic       sclk,     // Serial clock
  input  wire logic [3:0] io,       // Resolved data lines
  input  wire logic       dc8,      // Eight dummy clocks set
  input  wire logic       erase_go, // Erase starts
  input  wire logic       pwr_loss, // Power failure
  output logic      [3:0] q,        // Data lines driven
  output logic            suspend_flag,      // Suspend flag
  output logic            busy,     // Busy flag
  output logic            pd,       // Powered down
  output int              viol      // Host faults seen
);
  logic [7:0] op = 8'h0;
  int         n = 0;
  int         s;
  int         w;
  int         et = 0;
  time        t_rise = 0;
  time        t_fall = 0;
  time        t_res = 0;
  time        need = 0;

  function automatic logic sbit(input int i);
    if (op == flc_pkg::OP_UID)
      return i < 64 ? UID[63 - i] : 1'b1;
    if (op == flc_pkg::OP_RELEASE)
      return DEV[7 - i % 8];
    return i % 16 < 8 ? MFR[7 - i % 8] : DEV[7 - i % 8];
  endfunction : sbit

  // First read clock and lines per clock
  always_comb
  begin
    w = 1;
    s = 9999;
    case (op)
      flc_pkg::OP_ID_SGL:  s = 32;
      flc_pkg::OP_RELEASE: s = 32;
      flc_pkg::OP_UID:     s = 40;
      flc_pkg::OP_ID_DUAL:
      begin
        w = 2;
        s = dc8 ? 28 : 24;
      end
      flc_pkg::OP_ID_QUAD:
      begin
        w = 4;
        s = dc8 ? 26 : 24;
      end
      default: s = 9999;
    endcase
  end

  initial
  begin
    {suspend_flag, busy, pd, q} = 7'h0;
    viol = 0;
  end

  always @(posedge hclk)
    if (busy && et == 0)
      busy = 1'b0;
    else if (busy)
      et = et - 1;

  always @(posedge erase_go)
  begin
    busy = 1'b1;
    et = ERASE_CYC;
  end

  always @(posedge pwr_loss)
    {suspend_flag, busy, pd} = 3'h0;

  always @(negedge cs_n)
  begin
    t_fall = $time;
    if (t_fall - t_rise < need)
      viol = viol + 1;
    n = 0;
    op = 8'h0;
  end

  always @(posedge sclk)
    if (!cs_n)
    begin
      if (n < 8)
        op = {op[6:0], io[0]};
      else if (op == flc_pkg::OP_ID_SGL && n < 32 && io[0])
        viol = viol + 1;
      else if (op == flc_pkg::OP_ID_DUAL && n < 22 && io[1:0] != (n < 20 ? 2'h0 : 2'h3))
        viol = viol + 1;
      else if (op == flc_pkg::OP_ID_QUAD && n > 11 && n < 19 && io != (n < 18 ? 4'h0 : 4'hf))
        viol = viol + 1;
      n = n + 1;
    end

  // Released lines toggle so a stale bit never reads as data
  always @(negedge sclk)
    if (!cs_n)
    begin
      if (n >= s && (pd || busy ? op == flc_pkg::OP_RELEASE && !busy : 1'b1))
        for (int j = 0; j < w; j++)
          q[w == 1 ? 1 : w - 1 - j] = sbit((n - s) * w + j);
      else
        q = ~q;
    end

  always @(posedge cs_n)
  begin
    t_rise = $time;
    q = ~q;
    need = 0;
    if (n == 8 && op == flc_pkg::OP_PDOWN && !pd)
      pd = 1'b1;
    else if (op == flc_pkg::OP_RELEASE && !busy && (n == 8 || n > 32))
    begin
      need = n == 8 ? flc_pkg::T_RES1_NS : (pd ? flc_pkg::T_RES2_NS : 0);
      pd = 1'b0;
    end
    else if (n == 8 && op == flc_pkg::OP_RESUME && !pd && suspend_flag && !busy)
    begin
      suspend_flag = 1'b0;
      busy = 1'b1;
      t_res = $time;
    end
    else if (n == 8 && op == flc_pkg::OP_SUSPEND && !pd && !suspend_flag && busy)
    begin
      viol = t_fall - t_res < flc_pkg::T_ERS_NS ? viol + 1 : viol;
      suspend_flag = 1'b1;
      busy = 1'b0;
    end
  end
endmodule : flash_model

// ==== test/flash_resume_powerdown_id_tb.sv ====
/*
  Self-checking bench for the flash identification and power controller.
  Assumes the flash model beside it; this bench is the only bus master.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("ERROR %s exp %0h got %0h", n, e, g); \
    end \
  end
module flash_resume_powerdown_id_tb;
  localparam logic [7:0]  MFR = 8'h5a;                // Arbitrary value
  localparam logic [7:0]  DEV = 8'h17;                // Arbitrary value
  localparam logic [63:0] UID = 64'h0123456789abcdef; // Arbitrary value
  localparam logic [63:0] IDW = {48'h0, MFR, DEV};
  localparam logic [63:0] MS  = 64'hffff;
  typedef struct packed {
    logic [3:0]  cmd;
    logic [1:0]  cfg;
    logic [63:0] exp;
    logic [63:0] msk;
  } row_type;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        dc8;
  logic        erase_go;
  logic        pwr_loss;
  logic        hreadyout;
  logic        hresp;
  logic        cs_n;
  logic        sclk;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [3:0]  io_out;
  logic [3:0]  io_oe_n;
  logic [3:0]  io_in;
  logic [3:0]  mq;
  logic        suspend_flag;
  logic        busy;
  logic        pd;
  logic [63:0] rx;
  int          viol;
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  row_type     rows [9];

  always #5 hclk = ~hclk;
  assign io_in = (io_out & ~io_oe_n) | (mq & io_oe_n);

  flash_resume_powerdown_id #(.HALF_DIV(3)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cs_n(cs_n), .sclk(sclk),
    .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in));
  flash_model #(.MFR(MFR), .DEV(DEV), .UID(UID)) fm_u (
    .hclk(hclk), .cs_n(cs_n), .sclk(sclk), .io(io_in), .dc8(dc8), .erase_go(erase_go),
    .pwr_loss(pwr_loss), .q(mq), .suspend_flag(suspend_flag), .busy(busy), .pd(pd), .viol(viol));

  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  // One command frame, then its received data
  task automatic run(input logic [3:0] c);
    xfer(1'b1, flc_pkg::OFS_CMD, {28'h0, c}, q);
    do xfer(1'b0, flc_pkg::OFS_STAT, 32'h0, q); while (q[0] !== 1'b0);
    xfer(1'b0, flc_pkg::OFS_DLO, 32'h0, rx[31:0]);
    xfer(1'b0, flc_pkg::OFS_DHI, 32'h0, rx[63:32]);
  endtask : run

  task automatic pulse_erase;
    erase_go <= 1'b1;
    @(posedge hclk);
    erase_go <= 1'b0;
  endtask : pulse_erase

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      complete_run();
    end
  end

  initial
  begin
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dc8 = 1'b0;
    erase_go = 1'b0;
    pwr_loss = 1'b0;
    rows = '{'{flc_pkg::CMD_ID_SGL, 2'h0, IDW, MS}, '{flc_pkg::CMD_ID_DUAL, 2'h0, IDW, MS},
             '{flc_pkg::CMD_ID_DUAL, 2'h1, IDW, MS}, '{flc_pkg::CMD_ID_DUAL, 2'h3, IDW, MS},
             '{flc_pkg::CMD_ID_QUAD, 2'h0, IDW, MS}, '{flc_pkg::CMD_ID_QUAD, 2'h2, IDW, MS},
             '{flc_pkg::CMD_ID_QUAD, 2'h3, IDW, MS},
             '{flc_pkg::CMD_REL_ID, 2'h0, {56'h0, DEV}, 64'hff},
             '{flc_pkg::CMD_UID, 2'h1, UID, ~64'h0}};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i])
    begin
      dc8 <= rows[i].cfg[0];
      xfer(1'b1, flc_pkg::OFS_CFG, {30'h0, rows[i].cfg}, q);
      run(rows[i].cmd);
      `CHK("id data", rows[i].exp, rx & rows[i].msk);
      $display("row %0d done", i);
    end
    run(flc_pkg::CMD_PDOWN);
    `CHK("pd entered", 1'b1, pd);
    xfer(1'b0, flc_pkg::OFS_STAT, 32'h0, q);
    `CHK("pd status", 3'h4, q[2:0]);
    run(flc_pkg::CMD_ID_SGL);
    `CHK("pd id", 2'h1, {rx[15:0] === IDW[15:0], pd});
    run(flc_pkg::CMD_RELEASE);
    `CHK("released", 1'b0, pd);
    run(flc_pkg::CMD_PDOWN);
    run(flc_pkg::CMD_REL_ID);
    `CHK("release id", {1'b0, DEV}, {pd, rx[7:0]});
    $display("power test done");
    pulse_erase();
    run(flc_pkg::CMD_RESUME);
    `CHK("resume ignored", 2'h1, {suspend_flag, busy});
    run(flc_pkg::CMD_SUSPEND);
    `CHK("suspended", 2'h2, {suspend_flag, busy});
    run(flc_pkg::CMD_RESUME);
    `CHK("resumed", 2'h1, {suspend_flag, busy});
    xfer(1'b0, flc_pkg::OFS_STAT, 32'h0, q);
    `CHK("guard", 1'b1, q[1]);
    run(flc_pkg::CMD_SUSPEND);
    `CHK("held suspend", 2'h2, {suspend_flag, busy});
    pwr_loss <= 1'b1;
    @(posedge hclk);
    pwr_loss <= 1'b0;
    run(flc_pkg::CMD_RESUME);
    `CHK("lost resume", 3'h0, {suspend_flag, busy, pd});
    pulse_erase();
    run(flc_pkg::CMD_REL_ID);
    `CHK("busy release", 2'h1, {rx[7:0] === DEV, busy});
    $display("suspend test done");
    xfer(1'b1, flc_pkg::OFS_CMD, 32'h9, q);
    xfer(1'b0, flc_pkg::OFS_STAT, 32'h0, q);
    `CHK("cmd refused", 1'b0, q[0]);
    xfer(1'b0, 8'h20, 32'h0, q);
    `CHK("unmapped", 32'h0, q);
    `CHK("host faults", 0, viol);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    `CHK("reset pins", {8'hbe, 32'h0}, {cs_n, sclk, io_oe_n, hreadyout, hresp, hrdata});
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, flc_pkg::OFS_STAT, 32'h0, q);
    `CHK("reset status", 32'h0, q);
    $display("reset test done");
    complete_run();
  end
endmodule : flash_resume_powerdown_id_tb
